// *** src/smcs_defs.svh ***
`ifndef SMCS_DEFS_SVH
`define SMCS_DEFS_SVH
// How it works
// RULE1 - frame length code plus one, reset seven
// RULE2 - received frames right justified, upper zeros
// RULE3 - transmit only low frame length bits
// RULE4 - software right justifies transmit words
// RULE5 - receive only runs count plus one frames
// RULE6 - disable halts transfer, flushes both fifos
// RULE7 - some controls writable only while disabled
// RULE8 - sleep output rises after disable delay
// RULE9 - two select enables drive low selects
// RULE10 - divisor bit zero always reads zero
// RULE11 - zero divisor stops clock, else divide
// RULE12 - transmit empty when level at/below threshold
// RULE13 - receive full when level at/above threshold
// RULE14 - level registers show fifo entry counts
// RULE15 - collision bit six, cleared on read
// RULE16 - transmission error bit stays zero
// RULE17 - bit four rx full, three not empty
// RULE18 - bit two tx empty, one not full
// RULE19 - bit zero shows transfer in progress
// RULE20 - six mask bits reset to one
// RULE21 - masked status is raw and mask
// RULE22 - raw status ignores mask
// RULE23 - transfer direction selects valid data
// RULE24 - combined clear read clears four sources
// RULE25 - interrupt output ors masked sources
// RULE26 - overflow and underflow event sources

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SMCS_OFS_FRAME_CONTROL     8'h00
`define SMCS_OFS_FRAME_COUNT       8'h04
`define SMCS_OFS_GLOBAL_ENABLE     8'h08
`define SMCS_OFS_CONTROL_WORD_MODE 8'h0c
`define SMCS_OFS_SELECT_ENABLE     8'h10
`define SMCS_OFS_CLOCK_DIVISOR     8'h14
`define SMCS_OFS_TX_THRESHOLD      8'h18
`define SMCS_OFS_RX_THRESHOLD      8'h1c
`define SMCS_OFS_TX_LEVEL          8'h20
`define SMCS_OFS_RX_LEVEL          8'h24
`define SMCS_OFS_STATUS_FLAGS      8'h28
`define SMCS_OFS_IRQ_MASK          8'h2c
`define SMCS_OFS_IRQ_MASKED        8'h30
`define SMCS_OFS_IRQ_RAW           8'h34
`define SMCS_OFS_CLR_TXO           8'h38
`define SMCS_OFS_CLR_RXO           8'h3c
`define SMCS_OFS_CLR_RXU           8'h40
`define SMCS_OFS_CLR_MST           8'h44
`define SMCS_OFS_CLR_ALL           8'h48
`define SMCS_OFS_DATA_LO           8'h60
`define SMCS_OFS_DATA_HI           8'h9c

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SMCS_RST_FRAME_CONTROL     16'h0007
`define SMCS_RST_IRQ_MASK          6'h3f
`define SMCS_FLD_DFS_HI            3
`define SMCS_FLD_DIR_LO            8
`define SMCS_FLD_SCPOL             7
`define SMCS_SLEEP_CYC             4'h8
`endif

// *** src/smcs_pkg.sv ***
package smcs_pkg;
   // transfer engine states
   typedef enum logic [0:0] {
      SMCS_IDLE,
      SMCS_SHIFT
   } smcs_state_t;

   // transfer direction codes
   typedef enum logic [1:0] {
      SMCS_DIR_TXRX,
      SMCS_DIR_TX,
      SMCS_DIR_RX,
      SMCS_DIR_MEMRD
   } smcs_dir_t;
endpackage

// *** src/smcs_spi_master.sv ***
`timescale 1ns/100ps
`include "smcs_defs.svh"
module smcs_spi_master
   import smcs_pkg::*;
#(
   parameter int DEPTH = 16,                 // fifo entries
   parameter int WIDTH = 16                  // fifo entry width
) (
   input  wire logic        clk,             // peripheral clock
   input  wire logic        reset,           // sync, active high
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb access phase
   input  wire logic        pwrite,          // apb write
   input  wire logic [7:0]  paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic      [31:0] prdata,          // apb read data
   output logic             sclk_out,        // serial clock
   output logic             txd,             // serial data out
   input  wire logic        rxd,             // serial data in
   output logic      [1:0]  ss_n,            // select lines, active low
   input  wire logic        ss_in_n,         // foreign master selecting us
   output logic             sleep,           // clock may be stopped
   output logic             intr             // combined interrupt
);
   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------
   // state record
   // ----------------------------------------
   typedef struct packed {
      smcs_state_t                   st;        // engine state
      logic [15:0]                   ctrl0;     // frame control
      logic [15:0]                   frame_count_field;       // frame_count_field
      logic                          en;        // global enable
      logic [2:0]                    mw;        // control word mode
      logic [1:0]                    ser;       // select enables
      logic [15:0]                   baud;      // clock_divisor_value
      logic [3:0]                    txftl;     // tx threshold
      logic [3:0]                    rxftl;     // rx threshold
      logic [5:0]                    imr;       // interrupt mask
      logic                          txo;       // tx overflow sticky
      logic                          rxo;       // rx overflow sticky
      logic                          rxu;       // rx underflow sticky
      logic                          mst;       // contention sticky
      logic                          dcol;      // collision status
      logic [DEPTH-1:0][WIDTH-1:0]   txmem;     // tx storage
      logic [DEPTH-1:0][WIDTH-1:0]   rxmem;     // rx storage
      logic [AW-1:0]                 txwp;      // tx write index
      logic [AW-1:0]                 txrp;      // tx read index
      logic [AW:0]                   txcnt;     // tx entries
      logic [AW-1:0]                 rxwp;      // rx write index
      logic [AW-1:0]                 rxrp;      // rx read index
      logic [AW:0]                   rxcnt;     // rx entries
      logic [15:0]                   div_cnt;   // half period counter
      logic                          sclk_lvl;  // clock phase, 1 after lead edge
      logic [3:0]                    bit_cnt;   // bit within frame
      logic [WIDTH-1:0]              sh_tx;     // tx shifter
      logic [WIDTH-1:0]              sh_rx;     // rx shifter
      logic [16:0]                   rx_left;   // frames still to receive
      logic                          rx_phase;  // memory read receive part
      logic [3:0]                    sleep_cnt; // disable delay
      logic                          sleep;     // sleep output
      logic [31:0]                   prdata;    // read data output
      logic                          intr;      // interrupt output
      logic                          sclk;      // clock output
      logic                          txd;       // data output
      logic [1:0]                    ss_n;      // select output
   } smcs_regs_t;

   localparam smcs_regs_t RST = '{
      st:     SMCS_IDLE,
      ctrl0:  `SMCS_RST_FRAME_CONTROL,
      imr:    `SMCS_RST_IRQ_MASK,
      ss_n:   2'h3,
      default: '0
   };

   smcs_regs_t q;                            // registered state
   smcs_regs_t d;                            // next state

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // all behaviour in one pass: bus first so its clears lose to later sets
   always_comb begin
      logic            acc;
      logic            wr;
      logic            rd;
      logic            is_data;
      logic            tx_push;
      logic            tx_pop;
      logic            rx_push;
      logic            rx_pop;
      logic [WIDTH-1:0] rx_word;
      logic [5:0]      raw;
      logic [3:0]      dfs;
      smcs_dir_t       dir;
      logic            rx_valid;
      logic            more;
      logic [15:0]     half;
      d        = q;
      acc      = psel && !penable;
      wr       = acc && pwrite;
      rd       = acc && !pwrite;
      is_data  = (paddr >= `SMCS_OFS_DATA_LO) && (paddr <= `SMCS_OFS_DATA_HI);
      tx_push  = 1'b0;
      tx_pop   = 1'b0;
      rx_push  = 1'b0;
      rx_pop   = 1'b0;
      rx_word  = '0;
      dfs      = q.ctrl0[`SMCS_FLD_DFS_HI:0];
      dir      = smcs_dir_t'(q.ctrl0[`SMCS_FLD_DIR_LO+1:`SMCS_FLD_DIR_LO]);
      rx_valid = 1'b0;
      more     = 1'b0;
      half     = {1'b0, q.baud[15:1]};
      // RULE12 threshold compare
      raw[0]   = q.txcnt <= {1'b0, q.txftl};
      raw[1]   = q.txo;
      raw[2]   = q.rxu;
      raw[3]   = q.rxo;
      // RULE13 threshold compare
      raw[4]   = q.rxcnt >= {1'b0, q.rxftl};
      raw[5]   = q.mst;

      // read mux, data valid in the access phase
      d.prdata = '0;
      if (rd) begin
         unique case (paddr)
            `SMCS_OFS_FRAME_CONTROL:     d.prdata = {16'h0, q.ctrl0};
            `SMCS_OFS_FRAME_COUNT:       d.prdata = {16'h0, q.frame_count_field};
            `SMCS_OFS_GLOBAL_ENABLE:     d.prdata = {31'h0, q.en};
            `SMCS_OFS_CONTROL_WORD_MODE: d.prdata = {29'h0, q.mw};
            `SMCS_OFS_SELECT_ENABLE:     d.prdata = {30'h0, q.ser};
            `SMCS_OFS_CLOCK_DIVISOR:     d.prdata = {16'h0, q.baud};
            `SMCS_OFS_TX_THRESHOLD:      d.prdata = {28'h0, q.txftl};
            `SMCS_OFS_RX_THRESHOLD:      d.prdata = {28'h0, q.rxftl};
            // RULE14 entry counts
            `SMCS_OFS_TX_LEVEL:          d.prdata = 32'(q.txcnt);
            `SMCS_OFS_RX_LEVEL:          d.prdata = 32'(q.rxcnt);
            // RULE16 RULE17 RULE18 RULE19 status, error low
            `SMCS_OFS_STATUS_FLAGS:      d.prdata = {25'h0, q.dcol, 1'b0,
                                                     q.rxcnt == (AW+1)'(DEPTH), q.rxcnt != '0,
                                                     q.txcnt == '0, q.txcnt != (AW+1)'(DEPTH),
                                                     q.st == SMCS_SHIFT};
            `SMCS_OFS_IRQ_MASK:          d.prdata = {26'h0, q.imr};
            // RULE21 masked view
            `SMCS_OFS_IRQ_MASKED:        d.prdata = {26'h0, raw & q.imr};
            // RULE22 raw view
            `SMCS_OFS_IRQ_RAW:           d.prdata = {26'h0, raw};
            `SMCS_OFS_CLR_TXO:           d.prdata = {31'h0, q.txo};
            `SMCS_OFS_CLR_RXO:           d.prdata = {31'h0, q.rxo};
            `SMCS_OFS_CLR_RXU:           d.prdata = {31'h0, q.rxu};
            `SMCS_OFS_CLR_MST:           d.prdata = {31'h0, q.mst};
            `SMCS_OFS_CLR_ALL:           d.prdata = {31'h0, q.txo | q.rxo | q.rxu | q.mst};
            default: begin
               // data window reads the rx head; holes read zero
               if (is_data && q.rxcnt != '0) begin
                  d.prdata = {16'h0, q.rxmem[q.rxrp]};
               end
            end
         endcase
      end

      // read side effects, done before any set below
      if (rd) begin
         unique case (paddr)
            // RULE15 collision cleared by status read
            `SMCS_OFS_STATUS_FLAGS: d.dcol = 1'b0;
            `SMCS_OFS_CLR_TXO:      d.txo = 1'b0;
            `SMCS_OFS_CLR_RXO:      d.rxo = 1'b0;
            `SMCS_OFS_CLR_RXU:      d.rxu = 1'b0;
            `SMCS_OFS_CLR_MST:      d.mst = 1'b0;
            // RULE24 combined clear on read
            `SMCS_OFS_CLR_ALL: begin
               d.txo = 1'b0;
               d.rxo = 1'b0;
               d.rxu = 1'b0;
               d.mst = 1'b0;
            end
            default: begin
               if (is_data) begin
                  // RULE26 underflow on empty read
                  if (q.rxcnt == '0) begin
                     d.rxu = 1'b1;
                  end else begin
                     rx_pop = 1'b1;
                  end
               end
            end
         endcase
      end

      // register writes
      if (wr) begin
         unique case (paddr)
            `SMCS_OFS_GLOBAL_ENABLE: d.en  = pwdata[0];
            // RULE9 select enables
            `SMCS_OFS_SELECT_ENABLE: d.ser = pwdata[1:0];
            // RULE20 mask bits
            `SMCS_OFS_IRQ_MASK:      d.imr = pwdata[5:0];
            default: begin
               // RULE7 frame setup frozen while enabled
               if (!q.en) begin
                  unique case (paddr)
                     // RULE1 frame length code
                     `SMCS_OFS_FRAME_CONTROL:     d.ctrl0 = pwdata[15:0];
                     `SMCS_OFS_FRAME_COUNT:       d.frame_count_field = pwdata[15:0];
                     `SMCS_OFS_CONTROL_WORD_MODE: d.mw = pwdata[2:0];
                     // RULE10 divisor kept even
                     `SMCS_OFS_CLOCK_DIVISOR:     d.baud = {pwdata[15:1], 1'b0};
                     `SMCS_OFS_TX_THRESHOLD:      d.txftl = pwdata[3:0];
                     `SMCS_OFS_RX_THRESHOLD:      d.rxftl = pwdata[3:0];
                     default: begin
                     end
                  endcase
               end
               // words arriving while disabled are dropped, never pushed
               if (is_data && q.en) begin
                  // RULE26 overflow on full write
                  if (q.txcnt == (AW+1)'(DEPTH)) begin
                     d.txo = 1'b1;
                  end else begin
                     tx_push = 1'b1;
                  end
               end
            end
         endcase
      end

      // transfer engine
      unique case (q.st)
         SMCS_IDLE: begin
            d.sclk_lvl = 1'b0;
            // RULE11 no start without a clock
            if (q.en && q.baud != '0 && q.txcnt != '0) begin
               tx_pop     = 1'b1;
               // RULE23 receive only sends no data
               d.sh_tx    = (dir == SMCS_DIR_RX) ? '0 : q.txmem[q.txrp];
               d.sh_rx    = '0;
               d.bit_cnt  = '0;
               d.div_cnt  = '0;
               d.rx_phase = 1'b0;
               d.rx_left  = {1'b0, q.frame_count_field} + 17'h1;
               d.st       = SMCS_SHIFT;
            end
         end
         SMCS_SHIFT: begin
            // RULE11 divide by the even divisor
            if (q.baud != '0) begin
               if (q.div_cnt == half - 16'h1) begin
                  d.div_cnt = '0;
                  if (!q.sclk_lvl) begin
                     // leading edge samples the line
                     d.sclk_lvl = 1'b1;
                     d.sh_rx    = {q.sh_rx[WIDTH-2:0], rxd};
                  end else begin
                     d.sclk_lvl = 1'b0;
                     if (q.bit_cnt != dfs) begin
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        d.sh_tx   = {q.sh_tx[WIDTH-2:0], 1'b0};
                     end else begin
                        // RULE23 direction picks stored frames
                        rx_valid = (dir == SMCS_DIR_TXRX) || (dir == SMCS_DIR_RX) ||
                                   (dir == SMCS_DIR_MEMRD && q.rx_phase);
                        if (rx_valid) begin
                           // RULE2 upper bits already zero
                           rx_word = q.sh_rx;
                           // RULE26 overflow on full receive
                           if (q.rxcnt == (AW+1)'(DEPTH)) begin
                              d.rxo = 1'b1;
                           end else begin
                              rx_push = 1'b1;
                           end
                        end
                        d.sh_tx = '0;
                        if (dir == SMCS_DIR_RX || (dir == SMCS_DIR_MEMRD && q.rx_phase)) begin
                           // RULE5 count frames down to zero
                           d.rx_left = q.rx_left - 17'h1;
                           more      = q.rx_left != 17'h1;
                        end else if (q.txcnt != '0) begin
                           tx_pop  = 1'b1;
                           d.sh_tx = q.txmem[q.txrp];
                           more    = 1'b1;
                        end else if (dir == SMCS_DIR_MEMRD) begin
                           // command sent, turn to receiving
                           d.rx_phase = 1'b1;
                           d.rx_left  = {1'b0, q.frame_count_field} + 17'h1;
                           more       = 1'b1;
                        end
                        d.sh_rx   = '0;
                        d.bit_cnt = '0;
                        d.st      = more ? SMCS_SHIFT : SMCS_IDLE;
                     end
                  end
               end else begin
                  d.div_cnt = q.div_cnt + 16'h1;
               end
            end
            // RULE15 foreign select while transmitting
            if (!ss_in_n) begin
               d.dcol = 1'b1;
               d.mst  = 1'b1;
               d.st   = SMCS_IDLE;
            end
         end
      endcase

      // fifo bookkeeping
      if (tx_push) begin
         d.txmem[q.txwp] = pwdata[WIDTH-1:0];
         d.txwp          = q.txwp + AW'(1);
      end
      if (tx_pop) begin
         d.txrp = q.txrp + AW'(1);
      end
      d.txcnt = q.txcnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      if (rx_push) begin
         d.rxmem[q.rxwp] = rx_word;
         d.rxwp          = q.rxwp + AW'(1);
      end
      if (rx_pop) begin
         d.rxrp = q.rxrp + AW'(1);
      end
      d.rxcnt = q.rxcnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);

      // RULE6 disable halts and flushes
      if (!d.en) begin
         d.st       = SMCS_IDLE;
         d.sclk_lvl = 1'b0;
         d.txwp     = '0;
         d.txrp     = '0;
         d.txcnt    = '0;
         d.rxwp     = '0;
         d.rxrp     = '0;
         d.rxcnt    = '0;
      end

      // RULE8 sleep after a delay when disabled
      if (d.en) begin
         d.sleep_cnt = '0;
         d.sleep     = 1'b0;
      end else if (q.sleep_cnt != `SMCS_SLEEP_CYC) begin
         d.sleep_cnt = q.sleep_cnt + 4'h1;
      end else begin
         d.sleep = 1'b1;
      end

      // outputs, registered; interrupt from current state, the rest from next state
      // RULE25 or of masked sources
      d.intr = |(raw & q.imr);
      d.sclk = d.sclk_lvl ^ d.ctrl0[`SMCS_FLD_SCPOL];
      // RULE3 only low frame bits leave
      d.txd  = d.sh_tx[d.ctrl0[`SMCS_FLD_DFS_HI:0]];
      // RULE9 selects low only during a transfer
      d.ss_n = ~(d.ser & {2{d.st == SMCS_SHIFT}});
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign prdata   = q.prdata;
   assign sclk_out = q.sclk;
   assign txd      = q.txd;
   assign ss_n     = q.ss_n;
   assign sleep    = q.sleep;
   assign intr     = q.intr;
endmodule

// *** testbench/smcs_checker.sv ***
`timescale 1ns/100ps
// ----
// port-level checks of the serial master
// ----
module smcs_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [1:0]  ss_n,
   input wire logic        ss_in_n,
   input wire logic        sleep,
   input wire logic        intr
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic       rd_acc; // read access phase
   logic       wr_set; // write setup phase
   logic       en_q;   // enable as last written
   logic [3:0] off_q;  // cycles disabled, saturating
   assign rd_acc = psel && penable && !pwrite;
   assign wr_set = psel && !penable && pwrite;
   // shadow of the enable bit, so sleep can be judged from the bus alone
   always_ff @(posedge clk) begin
      if (reset) begin
         en_q <= 1'b0;
         off_q <= 4'h0;
      end else begin
         if (wr_set && paddr == 8'h08) en_q <= pwdata[0];
         off_q <= en_q ? 4'h0 : ((off_q == 4'hf) ? off_q : off_q + 4'h1);
      end
   end
   a_halt_on_off: assert property (wr_set && paddr == 8'h08 && !pwdata[0] |-> ##[1:3] ss_n == 2'b11)
      else $error("select still low after disable");
   a_sleep_when_off: assert property (off_q == 4'hf && !en_q |-> sleep)
      else $error("sleep missing while disabled");
   a_awake_when_on: assert property (en_q [*2] |-> !sleep)
      else $error("sleep while enabled");
   a_collision_stop: assert property (!ss_in_n && ss_n != 2'b11 |-> ##[1:3] ss_n == 2'b11)
      else $error("transfer not halted on foreign select");
   a_txerr_zero: assert property (rd_acc && paddr == 8'h28 |-> prdata[5] == 1'b0)
      else $error("transmission error flag set");
   a_divisor_even: assert property (rd_acc && paddr == 8'h14 |-> prdata[0] == 1'b0)
      else $error("odd divisor read back");
   a_level_bound: assert property (rd_acc && (paddr == 8'h20 || paddr == 8'h24) |-> prdata <= 32'h10)
      else $error("level above depth");
   a_mask_quiets: assert property (wr_set && paddr == 8'h2c && pwdata[5:0] == 6'h00 |-> ##2 !intr)
      else $error("interrupt with all sources masked");
endmodule
bind smcs_spi_master smcs_checker i_smcs_checker (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .ss_n(ss_n), .ss_in_n(ss_in_n),
   .sleep(sleep), .intr(intr));

// *** testbench/smcs_slave_model.sv ***
`timescale 1ns/100ps
// ----
// behavioural serial slave, leading-edge sampling, idle low clock
// ----
module smcs_slave_model (
   input  wire logic        clk,   // bench clock
   input  wire logic        sclk,  // serial clock from master
   input  wire logic        sel_n, // own select, active low
   input  wire logic        txd,   // master data out
   output logic             rxd,   // data back to master
   input  wire logic [15:0] reply, // word sent each frame
   input  wire logic [4:0]  len,   // frame bits
   output logic      [15:0] got    // last bits captured
);
   logic       sclk_p; // clock one cycle ago
   logic [4:0] idx_q;  // bits already sent
   logic       idle_q; // changing level off frame
   // no pull on the line, so an unselected slave must not look steady
   assign rxd = sel_n ? idle_q : reply[len - 5'd1 - idx_q];
   initial begin
      sclk_p = 1'b0;
      idx_q = 5'd0;
      idle_q = 1'b0;
      got = 16'h0;
   end
   // capture on rise, move to next bit after fall
   always @(posedge clk) begin
      sclk_p <= sclk;
      idle_q <= ~idle_q;
      if (sel_n) idx_q <= 5'd0;
      else if (sclk && !sclk_p) got <= {got[14:0], txd};
      else if (!sclk && sclk_p) idx_q <= (idx_q + 5'd1 == len) ? 5'd0 : idx_q + 5'd1;
   end
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   logic        clk, reset, psel, penable, pwrite, ss_in_n; // bench driven
   logic [7:0]  paddr;                                       // byte address
   logic [31:0] pwdata, prdata, rd_q, e_n, m_n;              // bus data, notes
   logic        sclk_out, txd, rxd, sleep, intr;             // design outputs, rxd from slave
   logic [1:0]  ss_n;                                        // selects
   logic [15:0] reply, got;                                  // slave word, capture
   logic [4:0]  len;                                         // frame bits
   logic [31:0] exp_q[$], msk_q[$];                          // pending reads
   int          err_total, cmp_count, cyc;                   // tallies
   always #5 clk = ~clk;
   smcs_spi_master i_smcs_spi_master (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sclk_out(sclk_out), .txd(txd),
      .rxd(rxd), .ss_n(ss_n), .ss_in_n(ss_in_n), .sleep(sleep), .intr(intr));
   smcs_slave_model i_smcs_slave_model (.clk(clk), .sclk(sclk_out), .sel_n(ss_n[0]), .txd(txd), .rxd(rxd),
      .reply(reply), .len(len), .got(got));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one bus transfer; a read leaves its expectation for the monitor
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) begin
         exp_q.push_back(d);
         msk_q.push_back(m);
      end
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      rd_q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
      apb(1'b0, a, e, m);
   endtask
   // bounded wait on a register field
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      rd(a, 32'h0, 32'h0);
      while ((rd_q & m) !== v && n < 300) begin
         rd(a, 32'h0, 32'h0);
         n++;
      end
      check(rd_q & m, v);
   endtask
   // read data seen in the access phase against the oldest note
   always @(posedge clk) begin
      if (psel && penable && !pwrite) begin
         e_n = exp_q.pop_front();
         m_n = msk_q.pop_front();
         if (m_n != 32'h0) check(prdata & m_n, e_n & m_n);
      end
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      int k, lv;
      logic [31:0] d, m;
      clk = 1'b0;
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ss_in_n = 1'b1;
      reply = 16'h0;
      len = 5'd8;
      {err_total, cmp_count, cyc} = '0;
      void'($urandom(42386));
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rd(8'h00, 32'h7);
      rd(8'h28, 32'h6);
      rd(8'h2c, 32'h3f);
      rd(8'h34, 32'h11);
      rd(8'h30, 32'h11);
      d = $urandom;
      wr(8'h14, d);
      rd(8'h14, {16'h0, d[15:1], 1'b0});
      // frozen divisor keeps every entry queued while filling
      wr(8'h14, 32'h0);
      wr(8'h18, 32'h4);
      wr(8'h1c, 32'h1);
      wr(8'h08, 32'h1);
      wr(8'h00, 32'h5);
      for (k = 1; k <= 17; k++) begin
         wr(8'h60, $urandom);
         lv = (k > 16) ? 16 : k;
         rd(8'h20, 32'(lv));
         rd(8'h34, 32'({k > 16, lv <= 4}), 32'h3);
         rd(8'h28, 32'({lv == 0, lv < 16, 1'b0}), 32'h6);
      end
      rd(8'h48, 32'h1);
      rd(8'h34, 32'h0, 32'h2);
      wr(8'h08, 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h00, 32'h7);
      repeat (6) @(posedge clk);
      check(32'(sleep), 32'h1);
      // one full-duplex frame for every legal length code
      wr(8'h14, 32'h4);
      wr(8'h10, 32'h1);
      for (k = 3; k <= 15; k++) begin
         m = (32'h1 << (k + 1)) - 32'h1;
         d = $urandom;
         reply <= 16'($urandom);
         len <= 5'(k + 1);
         wr(8'h00, 32'(k));
         wr(8'h08, 32'h1);
         wr(8'h60, d);
         rd(8'h28, 32'h1, 32'h1);
         poll(8'h24, 32'h1f, 32'h1);
         check({16'h0, got} & m, d & m);
         rd(8'h34, 32'h10, 32'h10);
         rd(8'h28, 32'h8, 32'h19);
         rd(8'h60, {16'h0, reply} & m);
         rd(8'h60, 32'h0, 32'h0);
         rd(8'h34, 32'h4, 32'h4);
         rd(8'h40, 32'h1);
         wr(8'h08, 32'h0);
      end
      // transmit only, receive only, memory read with three frames
      len <= 5'd8;
      wr(8'h04, 32'h2);
      for (k = 1; k <= 3; k++) begin
         wr(8'h00, 32'((k << 8) + 7));
         wr(8'h08, 32'h1);
         wr(8'h60, 32'h0);
         poll(8'h24, 32'h1f, (k == 1) ? 32'h0 : 32'h3);
         repeat (200) @(posedge clk);
         rd(8'h24, (k == 1) ? 32'h0 : 32'h3);
         wr(8'h08, 32'h0);
      end
      // foreign master grabs the bus in mid-frame
      wr(8'h00, 32'hf);
      wr(8'h14, 32'h8);
      wr(8'h08, 32'h1);
      wr(8'h60, 32'ha5c3);
      repeat (10) @(posedge clk);
      ss_in_n <= 1'b0;
      repeat (4) @(posedge clk);
      ss_in_n <= 1'b1;
      rd(8'h28, 32'h40, 32'h40);
      rd(8'h28, 32'h0, 32'h40);
      rd(8'h34, 32'h20, 32'h20);
      wr(8'h08, 32'h0);
      wr(8'h2c, 32'h0);
      rd(8'h30, 32'h0);
      check(32'(intr), 32'h0);
      wr(8'h2c, 32'h1);
      rd(8'h30, 32'h1);
      check(32'(intr), 32'h1);
      close_out();
   end
endmodule
